// File: logic/tmr_dual_timer.sv
// two 16-bit timer/counters with an apb register file
// assumes pins synchronous to CLK and an apb master as the only bus user
//
// Our own choice: register access over APB.
`timescale 1ns/100ps

module tmr_dual_timer import tmr_pkg::*; (
  // clock, reset, enable
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        CE,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // count and gate pins
  input  wire logic        COUNT_INPUT_A,
  input  wire logic        COUNT_INPUT_B,
  input  wire logic        GATE_PIN_A,
  input  wire logic        GATE_PIN_B,
  // interrupt service handshake
  input  wire logic        INT_ACK_A,
  input  wire logic        INT_ACK_B,
  output logic             TIMER_A_OVERFLOW_FLAG,
  output logic             TIMER_B_OVERFLOW_FLAG
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic [7:0]  run_reg, run_next;
  logic [7:0]  mode_reg, mode_next;
  logic [7:0]  pdiv_reg, pdiv_next;
  tmr_cnt_s    cnt_reg [2];
  tmr_cnt_s    cnt_next [2];
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;

  logic [1:0]  tick;
  logic [1:0]  fall;
  logic [1:0]  inc;
  logic [1:0]  ovf;
  logic [1:0]  run_bit;
  logic [1:0]  gpin_q;

  // ------------------------------------------------------------------
  // per-timer prescaler, edge detect and count enable
  // ------------------------------------------------------------------
  genvar i;
  for (i = 0; i < 2; i++) begin : g_tmr
    logic [6:0] ps_reg, ps_next, lim;
    logic       cin_d1_reg, cin_d1_next;
    logic       cin_d2_reg, cin_d2_next;
    logic       gpin_reg, gpin_next;
    logic [1:0] ps_sel;
    logic       ctr_sel, gate_en;

    assign ps_sel  = pdiv_reg[TMR_PS_LSB_A + TMR_PS_STRIDE*i +: 2];
    assign ctr_sel = mode_reg[TMR_CTR_BIT_A + TMR_MODE_STRIDE*i];
    assign gate_en = mode_reg[TMR_GATE_BIT_A + TMR_MODE_STRIDE*i];
    assign run_bit[i] = run_reg[TMR_RUN_BIT_A + TMR_RUN_STRIDE*i];

    always_comb begin
      unique case (ps_sel)
        TMR_PS_SEL_FAST: lim = TMR_DIV_FAST - 7'd1; // R1
        TMR_PS_SEL_SLOW: lim = TMR_DIV_SLOW - 7'd1; // R1
        default:         lim = TMR_DIV_STD - 7'd1;  // R1
      endcase
      tick[i]     = (ps_reg >= lim);
      ps_next     = tick[i] ? 7'd0 : ps_reg + 7'd1;
      cin_d1_next = (i == 0) ? COUNT_INPUT_A : COUNT_INPUT_B;
      cin_d2_next = cin_d1_reg;
      gpin_next   = (i == 0) ? GATE_PIN_A : GATE_PIN_B;
      fall[i]     = cin_d2_reg & ~cin_d1_reg; // R2 R3
      gpin_q[i]   = gpin_reg;
      inc[i] = run_bit[i] & (~gate_en | gpin_reg) // R5 R14
             & (ctr_sel ? fall[i] : tick[i]); // R6
    end

    always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
        ps_reg     <= 7'd0;
        cin_d1_reg <= 1'b0;
        cin_d2_reg <= 1'b0;
        gpin_reg   <= 1'b0;
      end else if (CE) begin
        ps_reg     <= ps_next;
        cin_d1_reg <= cin_d1_next;
        cin_d2_reg <= cin_d2_next;
        gpin_reg   <= gpin_next;
      end
    end
  end

  // ------------------------------------------------------------------
  // counting step for modes 13, 16 and reload
  // ------------------------------------------------------------------
  function automatic tmr_step_s tmr_step(tmr_cnt_s c, logic [1:0] m,
                                         logic en);
    tmr_step_s   r;
    logic [13:0] v13;
    logic [16:0] v16;
    logic [8:0]  v8;
    r     = '{cnt: c, ovf: 1'b0};
    v13   = {1'b0, c.hi, c.lo[4:0]} + 14'h1;
    v16   = {1'b0, c.hi, c.lo} + 17'h1;
    v8    = {1'b0, c.lo} + 9'h1;
    unique case (tmr_mode_e'(m))
      TMR_MODE_13: begin
        r.cnt.lo[7:TMR_M13_HI_LSB] = 3'h0; // R9
        if (en) begin
          r.cnt.hi = v13[12:5]; // R8
          r.cnt.lo = {3'h0, v13[4:0]}; // R8
          r.ovf    = v13[13];
        end
      end
      TMR_MODE_16: begin
        if (en) begin
          {r.ovf, r.cnt.hi, r.cnt.lo} = v16; // R7
        end
      end
      TMR_MODE_RLD: begin
        if (en) begin
          r.cnt.lo = v8[8] ? c.hi : v8[7:0]; // R10
          r.ovf    = v8[8];
        end
      end
      TMR_MODE_SPLIT: begin
        r.ovf = 1'b0;
      end
    endcase
    return r;
  endfunction : tmr_step

  // ------------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------------
  logic       setup, access, mapped, wr;
  logic [7:0] idx, rd, wdat;

  always_comb begin
    setup  = PSEL & ~PENABLE;
    access = PSEL & PENABLE & pready_reg;
    idx    = PADDR[9:2];
    wdat   = PWDATA[7:0];
    mapped = (PADDR[11:10] == 2'b00) && (PADDR[1:0] == 2'b00) &&
             (idx == TMR_IDX_RUN  || idx == TMR_IDX_MODE ||
              idx == TMR_IDX_LO_A || idx == TMR_IDX_LO_B ||
              idx == TMR_IDX_HI_A || idx == TMR_IDX_HI_B ||
              idx == TMR_IDX_PDIV);
    wr     = access & PWRITE & mapped;
    unique case (idx)
      TMR_IDX_RUN:  rd = run_reg;
      TMR_IDX_MODE: rd = mode_reg;
      TMR_IDX_LO_A: rd = cnt_reg[0].lo;
      TMR_IDX_LO_B: rd = cnt_reg[1].lo;
      TMR_IDX_HI_A: rd = cnt_reg[0].hi;
      TMR_IDX_HI_B: rd = cnt_reg[1].hi;
      TMR_IDX_PDIV: rd = pdiv_reg;
      default:      rd = 8'h00;
    endcase
    pready_next  = setup;
    pslverr_next = setup & ~mapped;
    prdata_next  = setup ? {24'h000000, (mapped ? rd : 8'h00)}
                         : prdata_reg;
  end

  // ------------------------------------------------------------------
  // counters, flags and software writes
  // ------------------------------------------------------------------
  tmr_step_s  st_a, st_b;
  logic [8:0] sp_lo, sp_hi;
  logic [1:0] mode_a, mode_b;

  always_comb begin
    mode_a  = mode_reg[TMR_MODE_LSB_A +: 2];
    mode_b  = mode_reg[TMR_MODE_LSB_A + TMR_MODE_STRIDE +: 2];
    st_a    = tmr_step(cnt_reg[0], mode_a, inc[0]);
    st_b    = tmr_step(cnt_reg[1], mode_b, inc[1]);
    sp_lo   = {1'b0, cnt_reg[0].lo} + {8'h00, inc[0]};
    sp_hi   = {1'b0, cnt_reg[0].hi} + {8'h00, tick[0] & run_bit[1]};
    cnt_next[0] = st_a.cnt;
    cnt_next[1] = st_b.cnt;
    ovf[0]  = st_a.ovf;
    ovf[1]  = st_b.ovf;
    if (tmr_mode_e'(mode_a) == TMR_MODE_SPLIT) begin
      cnt_next[0] = '{hi: sp_hi[7:0], lo: sp_lo[7:0]}; // R12
      ovf[0]      = sp_lo[8]; // R12
      ovf[1]      = sp_hi[8]; // R15
    end
    if (tmr_mode_e'(mode_b) == TMR_MODE_SPLIT) begin
      cnt_next[1] = cnt_reg[1]; // R11
      if (tmr_mode_e'(mode_a) != TMR_MODE_SPLIT) begin
        ovf[1] = 1'b0; // R11
      end
    end
    mode_next = mode_reg;
    pdiv_next = pdiv_reg;
    run_next  = run_reg;
    if (wr) begin
      unique case (idx)
        TMR_IDX_RUN:  run_next       = wdat;
        TMR_IDX_MODE: mode_next      = wdat;
        TMR_IDX_LO_A: cnt_next[0].lo = wdat;
        TMR_IDX_LO_B: cnt_next[1].lo = wdat;
        TMR_IDX_HI_A: cnt_next[0].hi = wdat;
        TMR_IDX_HI_B: cnt_next[1].hi = wdat;
        TMR_IDX_PDIV: pdiv_next      = wdat;
        default:      run_next       = run_reg;
      endcase
    end
    if (tmr_mode_e'(mode_a) == TMR_MODE_13) begin
      cnt_next[0].lo[7:TMR_M13_HI_LSB] = 3'h0; // R9
    end
    if (tmr_mode_e'(mode_b) == TMR_MODE_13) begin
      cnt_next[1].lo[7:TMR_M13_HI_LSB] = 3'h0; // R9
    end
    if (INT_ACK_A) begin
      run_next[TMR_FLAG_BIT_A] = 1'b0; // R13
    end
    if (INT_ACK_B) begin
      run_next[TMR_FLAG_BIT_A + TMR_RUN_STRIDE] = 1'b0; // R13
    end
    if (ovf[0]) begin
      run_next[TMR_FLAG_BIT_A] = 1'b1; // R13
    end
    if (ovf[1]) begin
      run_next[TMR_FLAG_BIT_A + TMR_RUN_STRIDE] = 1'b1; // R13
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      run_reg     <= TMR_RST_RUN;
      mode_reg    <= TMR_RST_MODE;
      pdiv_reg    <= TMR_RST_PDIV;
      cnt_reg[0]  <= '{hi: TMR_RST_CNT, lo: TMR_RST_CNT};
      cnt_reg[1]  <= '{hi: TMR_RST_CNT, lo: TMR_RST_CNT};
      prdata_reg  <= 32'h00000000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (CE) begin
      run_reg     <= run_next;
      mode_reg    <= mode_next;
      pdiv_reg    <= pdiv_next;
      cnt_reg[0]  <= cnt_next[0];
      cnt_reg[1]  <= cnt_next[1];
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign PRDATA  = prdata_reg;
  assign PREADY  = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign TIMER_A_OVERFLOW_FLAG = run_reg[TMR_FLAG_BIT_A];
  assign TIMER_B_OVERFLOW_FLAG = run_reg[TMR_FLAG_BIT_A + TMR_RUN_STRIDE];

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  logic wr_cnt_a;
  assign wr_cnt_a = wr && (idx == TMR_IDX_LO_A || idx == TMR_IDX_HI_A);

  tick_count_a: assert property (CE && !wr_cnt_a && run_bit[0] // R1
      && mode_a == TMR_MODE_16 && !mode_reg[TMR_CTR_BIT_A]
      && !mode_reg[TMR_GATE_BIT_A] && pdiv_reg[1:0] == TMR_PS_SEL_FAST
      |=> cnt_reg[0] == 16'($past(cnt_reg[0]) + 16'h1))
    else $error("timer a missed a fast tick");
  edge_only_a: assert property (CE && inc[0] && mode_reg[TMR_CTR_BIT_A] // R2
      |-> g_tmr[0].cin_d2_reg && !g_tmr[0].cin_d1_reg)
    else $error("counter a advanced without a falling edge");
  gate_block_a: assert property (mode_reg[TMR_GATE_BIT_A] && !gpin_q[0] // R5
      |-> !inc[0])
    else $error("gated timer a counted with gate low");
  upper_zero_a: assert property (CE && mode_a == TMR_MODE_13 // R9
      |=> cnt_reg[0].lo[7:5] == 3'h0)
    else $error("13-bit mode upper bits not zero");
  reload_lo_a: assert property (CE && !wr_cnt_a && inc[0] // R10
      && mode_a == TMR_MODE_RLD && cnt_reg[0].lo == 8'hff
      |=> cnt_reg[0].lo == $past(cnt_reg[0].hi)
          && TIMER_A_OVERFLOW_FLAG)
    else $error("auto reload failed");
  stop_split_b: assert property (CE && mode_b == TMR_MODE_SPLIT // R11
      && !(wr && (idx == TMR_IDX_LO_B || idx == TMR_IDX_HI_B))
      |=> $stable(cnt_reg[1]))
    else $error("timer b counted in split mode");
  flag_set_a: assert property (CE && ovf[0] // R13
      |=> TIMER_A_OVERFLOW_FLAG [*1])
    else $error("overflow did not set flag a");
  run_stop_a: assert property (CE && !run_bit[0] && !wr_cnt_a // R14
      && mode_a != TMR_MODE_SPLIT
      && (mode_a != TMR_MODE_13 || cnt_reg[0].lo[7:5] == 3'h0)
      |=> $stable(cnt_reg[0].lo))
    else $error("timer a counted while stopped");

  reload_seen_c: cover property (CE && ovf[0] && mode_a == TMR_MODE_RLD);
  split_hi_c:    cover property (CE && ovf[1]
                                 && mode_a == TMR_MODE_SPLIT);
  bus_err_c:     cover property (PREADY && PSLVERR);

endmodule : tmr_dual_timer

// File: logic/tmr_pkg.sv
// constants, types and field layout of the dual timer/counter block
// assumes an apb master and one 100 mhz clock; machine cycle = one clock
//
// Functional notes
// R1: in timer mode a timer advances once every 1, 12 or 96 machine cycles as its prescale select says.
// R2: in counter mode a timer advances on each falling edge seen on its count input.
// R3: a falling edge takes two machine cycles to detect, so the count rate is at most half the clock.
// R4: the outside source holds each count input level for at least one machine cycle.
// R5: with gating on, a timer counts only while its gate pin is high and its run bit is set.
// R6: the counter-select bit picks pin-edge counting when 1 and machine-cycle timing when 0.
// R7: the two-bit mode field picks 13-bit, 16-bit, 8-bit auto-reload or split/stop operation.
// R8: the 13-bit mode counts the low five bits of the low byte and all eight of the high byte.
// R9: in the 13-bit mode the top three bits of the low byte are held at zero.
// R10: in auto-reload mode only the low byte counts and reloads from the high byte on overflow.
// R11: timer b stops counting while its mode field holds the split value.
// R12: timer a in the split mode works as two independent 8-bit timer/counters; here the high byte only counts timer a's prescaled machine cycles.
// R13: overflow sets the timer flag; software writes or an interrupt acknowledge clear it.
// R14: each timer counts only while its run bit is set.
// R15: in split mode timer a's high byte counts machine cycles under timer b's run bit and sets timer b's flag.
package tmr_pkg;

  // ------------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ------------------------------------------------------------------
  localparam logic [7:0] TMR_IDX_RUN  = 8'h88;
  localparam logic [7:0] TMR_IDX_MODE = 8'h89;
  localparam logic [7:0] TMR_IDX_LO_A = 8'h8a;
  localparam logic [7:0] TMR_IDX_LO_B = 8'h8b;
  localparam logic [7:0] TMR_IDX_HI_A = 8'h8c;
  localparam logic [7:0] TMR_IDX_HI_B = 8'h8d;
  localparam logic [7:0] TMR_IDX_PDIV = 8'hd9;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] TMR_RST_RUN  = 8'h00;
  localparam logic [7:0] TMR_RST_MODE = 8'h00;
  localparam logic [7:0] TMR_RST_CNT  = 8'h00;
  localparam logic [7:0] TMR_RST_PDIV = 8'h00;

  // ------------------------------------------------------------------
  // field positions (timer b fields sit one stride above timer a)
  // ------------------------------------------------------------------
  localparam int TMR_RUN_BIT_A   = 4;
  localparam int TMR_FLAG_BIT_A  = 5;
  localparam int TMR_RUN_STRIDE  = 2;
  localparam int TMR_MODE_LSB_A  = 0;
  localparam int TMR_CTR_BIT_A   = 2;
  localparam int TMR_GATE_BIT_A  = 3;
  localparam int TMR_MODE_STRIDE = 4;
  localparam int TMR_PS_LSB_A    = 0;
  localparam int TMR_PS_STRIDE   = 2;
  localparam int TMR_M13_HI_LSB  = 5;

  // ------------------------------------------------------------------
  // prescale selects and divisions in machine cycles
  // ------------------------------------------------------------------
  localparam logic [1:0] TMR_PS_SEL_STD  = 2'b00;
  localparam logic [1:0] TMR_PS_SEL_FAST = 2'b01;
  localparam logic [1:0] TMR_PS_SEL_SLOW = 2'b10;
  localparam logic [6:0] TMR_DIV_STD     = 7'd12;
  localparam logic [6:0] TMR_DIV_FAST    = 7'd1;
  localparam logic [6:0] TMR_DIV_SLOW    = 7'd96;

  typedef enum logic [1:0] {
    TMR_MODE_13    = 2'b00,
    TMR_MODE_16    = 2'b01,
    TMR_MODE_RLD   = 2'b10,
    TMR_MODE_SPLIT = 2'b11
  } tmr_mode_e;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } tmr_cnt_s;

  typedef struct packed {
    tmr_cnt_s cnt;
    logic     ovf;
  } tmr_step_s;

endpackage : tmr_pkg

// File: tb/testbench.sv
// self-checking bench for the dual timer/counter
// assumes tmr_pkg, the timer and the pin model are compiled first
`timescale 1ns/100ps

module testbench import tmr_pkg::*;;
  logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, ack_a = 1'b0, ack_b = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, cnt_a, cnt_b, gate_a, gate_b;
  logic        flag_a, flag_b;
  logic        ce = 1'b1;
  int          bad_count = 0, comparisons = 0, n, v;
  int unsigned seed = 97;
  logic [7:0]  regs [7] = '{TMR_IDX_RUN, TMR_IDX_MODE, TMR_IDX_LO_A,
    TMR_IDX_LO_B, TMR_IDX_HI_A, TMR_IDX_HI_B, TMR_IDX_PDIV};

  always #5 clk = ~clk;

  tmr_dual_timer tmr_dual_timer_inst (.CLK(clk), .NRST(nrst), .CE(ce),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .COUNT_INPUT_A(cnt_a), .COUNT_INPUT_B(cnt_b), .GATE_PIN_A(gate_a),
    .GATE_PIN_B(gate_b), .INT_ACK_A(ack_a), .INT_ACK_B(ack_b),
    .TIMER_A_OVERFLOW_FLAG(flag_a), .TIMER_B_OVERFLOW_FLAG(flag_b));

  tmr_pins_model tmr_pins_model_inst (.clk(clk), .cnt_a(cnt_a),
    .cnt_b(cnt_b), .gate_a(gate_a), .gate_b(gate_b));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd);
  endtask : wr

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    check(rd, exp);
  endtask : rdchk

  task automatic preset(input logic [7:0] md, input logic [7:0] lo,
                        input logic [7:0] hi);
    wr(TMR_IDX_MODE, md);
    wr(TMR_IDX_LO_A, lo);
    wr(TMR_IDX_HI_A, hi);
  endtask : preset

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    foreach (regs[i]) rdchk(regs[i], 32'h0);
    apb(1'b0, 8'h00, 8'h00);
    check(err, 1'b1);
    check(rd, 32'h0);
    $display("reset and decode done");
    for (int i = 0; i < 5; i++) begin
      v = 32'hffff - (rnd() % 6);
      n = 1 + rnd() % 4;
      preset(8'h05, v[7:0], v[15:8]);
      wr(TMR_IDX_RUN, 8'h10);
      tmr_pins_model_inst.pulse(1'b0, n);
      v = v + n;
      rdchk(TMR_IDX_LO_A, v[7:0]);
      rdchk(TMR_IDX_HI_A, v[15:8]);
      check(flag_a, v > 32'hffff);
    end
    $display("counter 16-bit done");
    preset(8'h04, 8'hfe, 8'hff);
    rdchk(TMR_IDX_LO_A, 32'h1e);
    wr(TMR_IDX_RUN, 8'h10);
    tmr_pins_model_inst.pulse(1'b0, 3);
    rdchk(TMR_IDX_LO_A, 32'h01);
    rdchk(TMR_IDX_HI_A, 32'h00);
    check(flag_a, 1'b1);
    @(posedge clk) ack_a <= 1'b1;
    @(posedge clk) ack_a <= 1'b0;
    repeat (2) @(posedge clk);
    check(flag_a, 1'b0);
    $display("13-bit done");
    preset(8'h06, 8'hfe, 8'h80);
    tmr_pins_model_inst.pulse(1'b0, 3);
    rdchk(TMR_IDX_LO_A, 32'h81);
    rdchk(TMR_IDX_HI_A, 32'h80);
    $display("reload done");
    preset(8'h0d, 8'h00, 8'h00);
    tmr_pins_model_inst.pulse(1'b0, 2);
    rdchk(TMR_IDX_LO_A, 32'h00);
    tmr_pins_model_inst.gate(1'b0, 1'b1);
    tmr_pins_model_inst.pulse(1'b0, 2);
    rdchk(TMR_IDX_LO_A, 32'h02);
    wr(TMR_IDX_RUN, 8'h00);
    tmr_pins_model_inst.pulse(1'b0, 2);
    rdchk(TMR_IDX_LO_A, 32'h02);
    $display("gate and run done");
    wr(TMR_IDX_MODE, 8'h70);
    wr(TMR_IDX_LO_B, 8'h00);
    wr(TMR_IDX_RUN, 8'h40);
    tmr_pins_model_inst.pulse(1'b1, 3);
    rdchk(TMR_IDX_LO_B, 32'h00);
    wr(TMR_IDX_MODE, 8'h50);
    tmr_pins_model_inst.pulse(1'b1, 2);
    rdchk(TMR_IDX_LO_B, 32'h02);
    $display("timer b stop done");
    for (int p = 0; p < 3; p++) begin
      v = (p == 0) ? 1 : (p == 1) ? 12 : 96;
      preset(8'h01, 8'h00, 8'h00);
      wr(TMR_IDX_PDIV, (p == 0) ? 8'h01 : (p == 1) ? 8'h00 : 8'h02);
      wr(TMR_IDX_RUN, 8'h10);
      repeat (8 * v) @(posedge clk);
      wr(TMR_IDX_RUN, 8'h00);
      apb(1'b0, TMR_IDX_LO_A, 8'h00);
      check(rd >= 7 && rd <= 12, 1'b1);
    end
    $display("prescale done");
    preset(8'h07, 8'hff, 8'hff);
    wr(TMR_IDX_PDIV, 8'h01);
    wr(TMR_IDX_RUN, 8'h50);
    tmr_pins_model_inst.pulse(1'b0, 2);
    rdchk(TMR_IDX_LO_A, 32'h01);
    check(flag_a, 1'b1);
    check(flag_b, 1'b1);
    $display("split done");
    wr(TMR_IDX_RUN, 8'h90);
    @(posedge clk) ack_b <= 1'b1;
    @(posedge clk) ack_b <= 1'b0;
    repeat (2) @(posedge clk);
    check(flag_b, 1'b0);
    wr(TMR_IDX_RUN, 8'h00);
    preset(8'h01, 8'h00, 8'h00);
    wr(TMR_IDX_RUN, 8'h10);
    ce <= 1'b0;
    repeat (50) @(posedge clk);
    ce <= 1'b1;
    wr(TMR_IDX_RUN, 8'h00);
    rdchk(TMR_IDX_LO_A, 32'h03);
    $display("flag clear and enable done");
    test_done();
  end

  initial begin
    #500000;
    bad_count++;
    test_done();
  end
endmodule : testbench

// File: tb/tmr_pins_model.sv
// pin source for the dual timer bench: count and gate pins
// assumes pins are sampled on the rising edge of clk
`timescale 1ns/100ps

module tmr_pins_model (
  // clock
  input  wire logic clk,
  // pins
  output logic      cnt_a,
  output logic      cnt_b,
  output logic      gate_a,
  output logic      gate_b
);
  initial begin
    cnt_a = 1'b1;
    cnt_b = 1'b1;
    gate_a = 1'b0;
    gate_b = 1'b0;
  end

  // n falling edges, each level held one clock
  task automatic pulse(input bit b, input int n);
    repeat (2 * n) begin
      @(posedge clk);
      if (b) cnt_b <= ~cnt_b;
      else cnt_a <= ~cnt_a;
    end
    repeat (4) @(posedge clk);
  endtask : pulse

  task automatic gate(input bit b, input logic v);
    @(posedge clk);
    if (b) gate_b <= v;
    else gate_a <= v;
  endtask : gate
endmodule : tmr_pins_model
